//--- inc/mxc_map.vh
// Purpose: constants shared by the shared-bus mux controller files
// Assumes: included by bare name from the logic/ files
// Notes: register offsets are Avalon byte addresses, one word each
`ifndef MXC_MAP_VH
`define MXC_MAP_VH

// ============================================================
// clock and timing
`define MXC_CLK_NS 4
`define MXC_SETTLE_NS 16
`define MXC_SETTLE_CYC ((`MXC_SETTLE_NS + `MXC_CLK_NS - 1) / `MXC_CLK_NS)
`define MXC_GAP_NS 16
`define MXC_GAP_CYC ((`MXC_GAP_NS + `MXC_CLK_NS - 1) / `MXC_CLK_NS)
`define MXC_SYNC_CYC 3

// ============================================================
// sizes
`define MXC_NDEV 8
`define MXC_DEV_W 3
`define MXC_SEL_W 3
`define MXC_NIN 8
`define MXC_TBL_W 16
`define MXC_CNT_W 8

// ============================================================
// register byte addresses
`define MXC_A_CMD 4'h0
`define MXC_A_STATUS 4'h4
`define MXC_A_TABLE 4'h8
`define MXC_A_GAP 4'hc

// ============================================================
// command word fields
`define MXC_CMD_SEL 2:0
`define MXC_CMD_DEV 5:3
`define MXC_CMD_FUNC 6
`define MXC_CMD_VAR 7
`define MXC_CMD_CONST 15:8

// table write word fields
`define MXC_TBL_DATA 15:0
`define MXC_TBL_IDX 18:16

// status word bits
`define MXC_ST_BUSY 0
`define MXC_ST_TRUE 1
`define MXC_ST_COMP 2
`define MXC_ST_MISMATCH 3
`define MXC_ST_DONE 4
`define MXC_ST_REFUSED 5

// per-input codes in function-generator mode
`define MXC_CODE_ZERO 2'h0
`define MXC_CODE_ONE 2'h1
`define MXC_CODE_VAR 2'h2
`define MXC_CODE_NVAR 2'h3

// reset values
`define MXC_OE_OFF 8'hff
`define MXC_GAP_RST 8'h04

`endif

//--- logic/mxc_ctrl.v
// Purpose: drives a bank of tri-state 8-to-1 mux devices sharing one bus
// Assumes: 250 MHz CLOCK; device outputs Z and its complement come back on pins
// Notes: one device at a time is enabled, with a float gap before each enable
//
// Operation
// [R1] device routes input chosen by select binary
// [R2] true output equals input, complement inverts it
// [R3] output enable is active low
// [R4] enable high floats both device outputs
// [R5] up to 128 devices may share output; the controller drives only eight enables (MUX_OE_N)
// [R6] only one sharing device enabled at once
// [R7] enable low intervals never overlap, even switching
// [R8] function generator: constants or fourth variable inputs
`timescale 1ns/1ps
`include "mxc_map.vh"

module mxc_ctrl
(
   input wire CLOCK,                            // system clock
   input wire RESET_N,                          // async reset, active low
   input wire [3:0] AVS_ADDRESS,                // byte address
   input wire AVS_READ,                         // read request
   input wire AVS_WRITE,                        // write request
   input wire [31:0] AVS_WRITEDATA,             // write data
   output reg [31:0] AVS_READDATA,              // read data
   output reg AVS_WAITREQUEST,                  // stall while high
   output reg [`MXC_SEL_W-1:0] SELECT_LINES,    // shared select lines
   output reg [`MXC_NIN-1:0] DATA_INPUTS,       // shared data inputs
   output reg [`MXC_NDEV-1:0] MUX_OE_N,         // per-device enables, low drives
   input wire BUS_TRUE,                         // shared true output pin
   input wire BUS_COMP                          // shared complement output pin
);

   // ============================================================
   // states
   localparam ST_IDLE = 3'h0;
   localparam ST_GAP = 3'h1;
   localparam ST_LOAD = 3'h2;
   localparam ST_DRIVE = 3'h3;
   localparam ST_SETTLE = 3'h4;
   localparam ST_RELEASE = 3'h5;
   localparam [`MXC_CNT_W-1:0] GAP_MIN = `MXC_GAP_CYC;
   localparam [`MXC_CNT_W-1:0] SETTLE_LEN = `MXC_SETTLE_CYC + `MXC_SYNC_CYC;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [`MXC_CNT_W-1:0] count;
   reg [`MXC_CNT_W-1:0] next_count;
   reg [`MXC_CNT_W-1:0] gap_len;
   reg [`MXC_SEL_W-1:0] cmd_sel;
   reg [`MXC_DEV_W-1:0] cmd_dev;
   reg cmd_func;
   reg cmd_var;
   reg [`MXC_NIN-1:0] cmd_const;
   reg result_true;
   reg result_comp;
   reg mismatch;
   reg done;
   reg refused;
   reg true_s1;
   reg true_s2;
   reg true_s3;
   reg comp_s1;
   reg comp_s2;
   reg comp_s3;
   reg true_level;
   reg comp_level;
   wire [`MXC_TBL_W-1:0] tbl_word;
   wire [`MXC_NIN-1:0] func_inputs;
   wire busy;
   wire acc;
   wire wr_cmd;
   wire wr_tbl;
   wire [`MXC_CNT_W-1:0] gap_use;

   assign busy = (state != ST_IDLE);
   // an access completes on the edge where waitrequest stands low
   assign acc = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
   assign wr_cmd = acc & AVS_WRITE & (AVS_ADDRESS == `MXC_A_CMD);
   assign wr_tbl = acc & AVS_WRITE & (AVS_ADDRESS == `MXC_A_TABLE);
   // never shorter than the device's worst disable time
   assign gap_use = (gap_len < GAP_MIN) ? GAP_MIN : gap_len;

   // ============================================================
   // bus slave handshake: one wait cycle per access
   always @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0;
      end
      else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST)
      begin
         AVS_WAITREQUEST <= 1'b0;
         AVS_READDATA <= 32'h0;
         if (AVS_READ)
         begin
            case (AVS_ADDRESS)
               `MXC_A_CMD:
               begin
                  AVS_READDATA[`MXC_CMD_SEL] <= cmd_sel;
                  AVS_READDATA[`MXC_CMD_DEV] <= cmd_dev;
                  AVS_READDATA[`MXC_CMD_FUNC] <= cmd_func;
                  AVS_READDATA[`MXC_CMD_VAR] <= cmd_var;
                  AVS_READDATA[`MXC_CMD_CONST] <= cmd_const;
               end
               `MXC_A_STATUS:
               begin
                  AVS_READDATA[`MXC_ST_BUSY] <= busy;
                  AVS_READDATA[`MXC_ST_TRUE] <= result_true;
                  AVS_READDATA[`MXC_ST_COMP] <= result_comp;
                  AVS_READDATA[`MXC_ST_MISMATCH] <= mismatch;
                  AVS_READDATA[`MXC_ST_DONE] <= done;
                  AVS_READDATA[`MXC_ST_REFUSED] <= refused;
               end
               `MXC_A_GAP:
               begin
                  AVS_READDATA[`MXC_CNT_W-1:0] <= gap_len;
               end
               default:
               begin
                  AVS_READDATA <= 32'h0;   // table and holes read zero
               end
            endcase
         end
      end
      else
      begin
         AVS_WAITREQUEST <= 1'b1;
      end
   end

   // ============================================================
   // command and gap registers; a command while busy is refused
   always @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cmd_sel <= 3'h0;
         cmd_dev <= 3'h0;
         cmd_func <= 1'b0;
         cmd_var <= 1'b0;
         cmd_const <= 8'h00;
         gap_len <= `MXC_GAP_RST;
         refused <= 1'b0;
      end
      else
      begin
         if (wr_cmd & ~busy)
         begin
            cmd_sel <= AVS_WRITEDATA[`MXC_CMD_SEL];
            cmd_dev <= AVS_WRITEDATA[`MXC_CMD_DEV];
            cmd_func <= AVS_WRITEDATA[`MXC_CMD_FUNC];
            cmd_var <= AVS_WRITEDATA[`MXC_CMD_VAR];
            cmd_const <= AVS_WRITEDATA[`MXC_CMD_CONST];
            refused <= 1'b0;
         end
         else if (wr_cmd)
         begin
            refused <= 1'b1;
         end
         if (acc & AVS_WRITE & (AVS_ADDRESS == `MXC_A_GAP))
         begin
            gap_len <= AVS_WRITEDATA[`MXC_CNT_W-1:0];
         end
      end
   end

   // ============================================================
   // per-device function table
   mxc_tbl u_tbl
   (
      .clk(CLOCK),
      .wr_en(wr_tbl),
      .wr_addr(AVS_WRITEDATA[`MXC_TBL_IDX]),
      .wr_data(AVS_WRITEDATA[`MXC_TBL_DATA]),
      .rd_addr(cmd_dev),
      .rd_data(tbl_word)
   );

   // each data input tied low, high, to the fourth variable or its inverse
   genvar gi;
   generate
      for (gi = 0; gi < `MXC_NIN; gi = gi + 1)
      begin : g_func
         assign func_inputs[gi] =
            (tbl_word[2*gi+1:2*gi] == `MXC_CODE_ONE) ? 1'b1 :
            (tbl_word[2*gi+1:2*gi] == `MXC_CODE_VAR) ? cmd_var :
            (tbl_word[2*gi+1:2*gi] == `MXC_CODE_NVAR) ? ~cmd_var : 1'b0; // R8
      end
   endgenerate

   // ============================================================
   // pin synchronisers; a level counts once stages two and three agree
   always @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         true_s1 <= 1'b0;
         true_s2 <= 1'b0;
         true_s3 <= 1'b0;
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
         comp_s3 <= 1'b0;
         true_level <= 1'b0;
         comp_level <= 1'b0;
      end
      else
      begin
         true_s1 <= BUS_TRUE;
         true_s2 <= true_s1;
         true_s3 <= true_s2;
         comp_s1 <= BUS_COMP;
         comp_s2 <= comp_s1;
         comp_s3 <= comp_s2;
         if (true_s2 == true_s3)
         begin
            true_level <= true_s3;
         end
         if (comp_s2 == comp_s3)
         begin
            comp_level <= comp_s3;
         end
      end
   end

   // ============================================================
   // sequencer next state
   always @*
   begin
      next_state = state;
      next_count = count;
      case (state)
         ST_IDLE:
         begin
            if (wr_cmd)
            begin
               next_state = ST_GAP;
               next_count = 8'h00;
            end
         end
         ST_GAP:
         begin
            // every enable already high: let the last driver float first
            next_count = count + 8'h01;
            if (next_count >= gap_use)
            begin
               next_state = ST_LOAD;   // R7
            end
         end
         ST_LOAD:
         begin
            next_state = ST_DRIVE;
            next_count = 8'h00;
         end
         ST_DRIVE:
         begin
            next_state = ST_SETTLE;
            next_count = 8'h00;
         end
         ST_SETTLE:
         begin
            next_count = count + 8'h01;
            if (next_count >= SETTLE_LEN)
            begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE:
         begin
            next_state = ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
            next_count = 8'h00;
         end
      endcase
   end

   // ============================================================
   // sequencer registers and pin drive
   always @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state <= ST_IDLE;
         count <= 8'h00;
         SELECT_LINES <= 3'h0;
         DATA_INPUTS <= 8'h00;
         MUX_OE_N <= `MXC_OE_OFF;   // R4
         result_true <= 1'b0;
         result_comp <= 1'b0;
         mismatch <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         case (state)
            ST_IDLE:
            begin
               if (wr_cmd)
               begin
                  done <= 1'b0;
               end
            end
            ST_LOAD:
            begin
               // select and data settle while every device still floats
               SELECT_LINES <= cmd_sel;   // R1
               DATA_INPUTS <= cmd_func ? func_inputs : cmd_const;   // R8
            end
            ST_DRIVE:
            begin
               // exactly one enable low, the rest stay high
               MUX_OE_N <= ~(8'h01 << cmd_dev);   // R3 R5 R6
            end
            ST_SETTLE:
            begin
               if (next_state == ST_RELEASE)
               begin
                  result_true <= true_level;
                  result_comp <= comp_level;
                  mismatch <= ~(true_level ^ comp_level);   // R2
               end
            end
            ST_RELEASE:
            begin
               MUX_OE_N <= `MXC_OE_OFF;   // R4 R7
               done <= 1'b1;
            end
            default:
            begin
               MUX_OE_N <= MUX_OE_N;
            end
         endcase
      end
   end

endmodule // mxc_ctrl

//--- logic/mxc_tbl.v
// Purpose: per-device function table, eight words of sixteen bits
// Assumes: one write port and one read port on the same clock
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
`include "mxc_map.vh"

module mxc_tbl
(
   input wire clk,                              // system clock
   input wire wr_en,                            // write strobe
   input wire [`MXC_DEV_W-1:0] wr_addr,         // write entry
   input wire [`MXC_TBL_W-1:0] wr_data,         // write word
   input wire [`MXC_DEV_W-1:0] rd_addr,         // read entry
   output reg [`MXC_TBL_W-1:0] rd_data          // registered read word
);

   reg [`MXC_TBL_W-1:0] mem [0:`MXC_NDEV-1];

   // ============================================================
   // storage; no reset, software loads it before use
   always @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // mxc_tbl

//--- verif/mxc_bank.sv
// Purpose: eight tri-state 8-to-1 mux devices on one wire pair
// Assumes: no propagation delay modelled
// Notes: eight devices, well under the 128 limit of one wire
`timescale 1ns/1ps
module mxc_bank
(
   input wire [2:0] sel, // shared selects
   input wire [7:0] din, // shared data inputs
   input wire [7:0] oe_n, // per-device enables
   input wire fault, // breaks the complement
   output wire z_true, // resolved true wire
   output wire z_comp // resolved complement wire
);
   // ==========================================
   // devices; all share sel and din, so two enabled at once drive the same level
   tri bus_t;
   tri bus_c;
   reg last_t = 1'b0;
   reg last_c = 1'b1;
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1)
      begin : g_dev
         assign bus_t = oe_n[k] ? 1'bz : din[sel];
         assign bus_c = oe_n[k] ? 1'bz : (din[sel] ^ ~fault);
      end
   endgenerate
   // no pull-up, so a floating wire shows the inverse of its last level
   always @(bus_t or bus_c)
   begin
      if (bus_t !== 1'bz)
         last_t = bus_t;
      if (bus_c !== 1'bz)
         last_c = bus_c;
   end
   assign z_true = (bus_t === 1'bz) ? ~last_t : bus_t;
   assign z_comp = (bus_c === 1'bz) ? ~last_c : bus_c;
endmodule // mxc_bank

//--- verif/mxc_ctrl_properties.sv
// Purpose: port checks for the mux bank controller
// Assumes: bound to mxc_ctrl, one clock domain
// Notes: enable timing checked on the per-device enables
`timescale 1ns/1ps
`include "mxc_map.vh"
module mxc_props
(
   input wire CLOCK, // clock
   input wire RESET_N, // reset, active low
   input wire [3:0] AVS_ADDRESS, // byte address
   input wire AVS_READ, // read request
   input wire AVS_WRITE, // write request
   input wire AVS_WAITREQUEST, // stall
   input wire [`MXC_SEL_W-1:0] SELECT_LINES, // selects
   input wire [`MXC_NIN-1:0] DATA_INPUTS, // data inputs
   input wire [`MXC_NDEV-1:0] MUX_OE_N // enables
);
   // ==========================================
   // shared clocking and float flag
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);
   wire idle = &MUX_OE_N;
   property p_one_dev;
      $onehot0(~MUX_OE_N);
   endproperty
   a_one_dev: assert property (p_one_dev) else $error("two enables low");
   property p_gap;
      $rose(idle) |-> idle [*4];
   endproperty
   a_gap: assert property (p_gap) else $error("float gap short");
   property p_lead;
      $fell(idle) |-> $past(idle, 4);
   endproperty
   a_lead: assert property (p_lead) else $error("enable without float");
   // a command taken while floating keeps every enable high for the minimum gap plus load and drive
   property p_float;
      AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == `MXC_A_CMD) && idle |=> idle [*6];
   endproperty
   a_float: assert property (p_float) else $error("enable before float gap");
   property p_hold;
      $fell(idle) |-> (!idle) [*8] ##1 idle;
   endproperty
   a_hold: assert property (p_hold) else $error("enable length wrong");
   property p_steady;
      !idle |-> $stable({SELECT_LINES, DATA_INPUTS});
   endproperty
   a_steady: assert property (p_steady) else $error("inputs moved while driving");
   property p_pulse;
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
   endproperty
   a_pulse: assert property (p_pulse) else $error("wait low too long");
   property p_answer;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet;
      !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
endmodule // mxc_props
bind mxc_ctrl mxc_props i_mxc_props (.CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SELECT_LINES(SELECT_LINES),
   .DATA_INPUTS(DATA_INPUTS), .MUX_OE_N(MUX_OE_N));

//--- verif/mxc_ctrl_test.sv
// Purpose: register-level tests of the mux bank controller
// Assumes: 250 MHz clock, Avalon master tasks
// Notes: results read back through the status word
`timescale 1ns/1ps
`include "mxc_map.vh"
module mxc_ctrl_test;
   reg clock = 1'b0;
   reg reset_n = 1'b0;
   reg [3:0] addr = 4'h0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wdat = 32'h0;
   reg fault = 1'b0;
   wire [31:0] rdat;
   wire wait_r;
   wire [2:0] sel;
   wire [7:0] din;
   wire [7:0] oe_n;
   wire z_t;
   wire z_c;
   integer fails = 0;
   integer comparisons = 0;
   integer cyc = 0;
   integer s;
   integer v;
   reg [31:0] got;
   reg [7:0] d;
   reg b;
   // ==========================================
   // clock, parts and watchdog
   always #2 clock = ~clock;
   mxc_ctrl i_mxc_ctrl (.CLOCK(clock), .RESET_N(reset_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
      .SELECT_LINES(sel), .DATA_INPUTS(din), .MUX_OE_N(oe_n), .BUS_TRUE(z_t), .BUS_COMP(z_c));
   mxc_bank i_mxc_bank (.sel(sel), .din(din), .oe_n(oe_n), .fault(fault), .z_true(z_t),
      .z_comp(z_c));
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // one access, held until wait is sampled low
   // only the watchdog ends a wait that never sees waitrequest low
   task bus(input w, input [3:0] a, input [31:0] wd);
      begin
         @(posedge clock);
         addr <= a;
         rd <= !w;
         wr <= w;
         wdat <= wd;
         do
            @(posedge clock);
         while (wait_r !== 1'b0);
         got = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   // command, then poll busy and compare the low status bits
   task run_cmd(input [31:0] cmd, input [5:0] exp);
      integer k;
      begin
         bus(1'b1, `MXC_A_CMD, cmd);
         got = 32'h1;
         k = 0;
         while (got[0] !== 1'b0 && k < 40)
         begin
            bus(1'b0, `MXC_A_STATUS, 32'h0);
            k = k + 1;
         end
         check("status", {26'h0, got[5:0]}, {26'h0, exp});
      end
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      bus(1'b0, `MXC_A_STATUS, 32'h0);
      check("status rst", got, 32'h0);
      bus(1'b0, `MXC_A_GAP, 32'h0);
      check("gap rst", got, 32'h4);
      bus(1'b0, `MXC_A_TABLE, 32'h0);
      check("table", got, 32'h0);
      bus(1'b1, 4'h2, 32'hff);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", got, 32'h0);
      check("oe rst", {24'h0, oe_n}, 32'hff);
      bus(1'b1, `MXC_A_GAP, 32'ha);
      bus(1'b0, `MXC_A_GAP, 32'h0);
      check("gap rw", got, 32'ha);
      $display("test reset done");
      // one-hot data for odd s, one-cold for even s, so a wrong select reads the opposite level
      for (s = 0; s < 8; s = s + 1)
      begin
         b = s % 2;
         d = b ? (8'h01 << s) : ~(8'h01 << s);
         run_cmd({16'h0, d, 2'b00, 3'd7 - s[2:0], s[2:0]}, {3'b010, ~b, b, 1'b0});
         check("select", {29'h0, sel}, s);
         check("data", {24'h0, din}, {24'h0, d});
         check("oe off", {24'h0, oe_n}, 32'hff);
      end
      $display("test direct done");
      bus(1'b1, `MXC_A_CMD, {16'h0, 8'h01, 8'h08});
      run_cmd({16'h0, 8'hfe, 8'h00}, 6'b110010);
      $display("test refuse done");
      bus(1'b1, `MXC_A_TABLE, {13'h0, 3'd2, 16'he4e4});
      for (v = 0; v < 2; v = v + 1)
      begin
         for (s = 0; s < 8; s = s + 1)
         begin
            b = (s % 4 == 0) ? 1'b0 : (s % 4 == 1) ? 1'b1 : (s % 4 == 2) ? v[0] : ~v[0];
            run_cmd({16'h0, 8'h00, v[0], 4'b1010, s[2:0]}, {3'b010, ~b, b, 1'b0});
         end
      end
      $display("test function done");
      // a gap below the minimum must still float four cycles
      bus(1'b1, `MXC_A_GAP, 32'h1);
      bus(1'b0, `MXC_A_GAP, 32'h0);
      check("gap low", got, 32'h1);
      fault <= 1'b1;
      run_cmd({16'h0, 8'h00, 8'h00}, 6'b011000);
      fault <= 1'b0;
      $display("test fault done");
      tally_and_finish;
   end
endmodule // mxc_ctrl_test
